// ### logic/tdmec_pkg.sv
/*
 Shared constants and types of the TDM error classifier.
 Assumes a 32-bit Avalon-MM register port and byte addresses.
*/
`default_nettype none
package tdmec_pkg;
  // ****************************************
  // Error codes of the interrupt descriptor
  // ****************************************
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_INTERNAL_BUFFER_ERROR = 4'h1;
  localparam logic [3:0] ERR_FRAME_ALIGNMENT_CHANGE = 4'h2;
  localparam logic [3:0] ERR_OWNER = 4'h3;
  // ****************************************
  // Register byte offsets and fields
  // ****************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TXEN = 4'h4;
  localparam logic [3:0] REG_RXEN = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  localparam int CTRL_CHAN_BIT = 0;
  localparam int CTRL_TRI_BIT = 1;
  localparam int CTRL_MAP_LSB = 4;
  localparam int MAP_W = 4;
  localparam int ST_INTERNAL_BUFFER_ERROR = 0;
  localparam int ST_TX_FRAME_ALIGNMENT_CHANGE = 1;
  localparam int ST_RX_FRAME_ALIGNMENT_CHANGE = 2;
  localparam int ST_OWNER = 3;
  localparam int ST_FROZEN = 4;
  localparam int STICKY_W = 4;
  localparam logic DIR_TX = 1'b0;
  localparam logic DIR_RX = 1'b1;
  // ****************************************
  // Carriers
  // ****************************************
  // Interrupt descriptor: error code sits in bits 19:16
  typedef struct packed {
    logic [11:0] rsvd_hi;
    logic [3:0] err;
    logic [7:0] rsvd_lo;
    logic dir;
    logic [6:0] chan;
  } tdmec_desc_type;
  typedef struct packed {
    logic valid;
    logic dir;
    logic [6:0] chan;
  } tdmec_event_type;
  typedef enum logic [1:0] {
    WALK_IDLE,
    WALK_TX,
    WALK_RX
  } tdmec_walk_type;
endpackage
`default_nettype wire

// ### logic/tdmec_top.sv
/*
 Error classifier and frame-alignment recovery for one channel group.
 Assumes channel engines on clk_sys drive the event inputs as pulses,
 sync pins are asynchronous, and software re-arms tx after recovery.
*/
// What this block does
// - Four-bit error code at bits 19:16
// - Code 1 on internal underflow or overflow
// - Code 2 to all channels on misaligned sync
// - Tx misalignment deactivates all tx channels, mapped groups
// - No tx descriptor updates afterwards; interrupts only with tx_req_done
// - Stop polling descriptors of active tx channels
// - Tx data idles: ones or three-state
// - Rx misalignment ends busy messages of enabled rx channels with error
// - Rx channels stay enabled after misalignment
// - Owner error when descriptor not yet handed over
// - Owner error when status write-back fails
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Frame flywheel
// ****************************************
module tdmec_flywheel #(
  parameter int FRAME_BITS = 256
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic bit_en,
  input wire logic sync_in,
  output logic frame_alignment_change
);
  import tdmec_pkg::*;
  localparam int CW = $clog2(FRAME_BITS);
  logic [CW-1:0] cnt_q, cnt_d;
  logic lock_q, lock_d, frame_alignment_change_q, frame_alignment_change_d;
  always_comb begin
    cnt_d = cnt_q;
    lock_d = lock_q;
    frame_alignment_change_d = 1'b0;
    if (bit_en) begin
      if (sync_in) begin
        // Sync marks bit 0; elsewhere it is out of step
        frame_alignment_change_d = lock_q && (cnt_q != '0);
        lock_d = 1'b1;
        cnt_d = CW'(1);
      end else if (cnt_q == CW'(FRAME_BITS - 1)) begin
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      lock_q <= 1'b0;
      frame_alignment_change_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      lock_q <= lock_d;
      frame_alignment_change_q <= frame_alignment_change_d;
    end
  end
  assign frame_alignment_change = frame_alignment_change_q;
endmodule

// ****************************************
// Top
// ****************************************
module tdmec_top #(
  parameter int NUM_CH = 8,
  parameter int BIT_DIV = 16,
  parameter int FRAME_BITS = 256
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic tx_sync_pin,
  input wire logic rx_sync_pin,
  input wire logic tx_bit_in,
  output logic tx_serial_data_out,
  output logic tx_serial_data_oe,
  input wire tdmec_pkg::tdmec_event_type buf_evt,
  input wire tdmec_pkg::tdmec_event_type own_evt,
  input wire tdmec_pkg::tdmec_event_type store_fail_evt,
  input wire logic [NUM_CH-1:0] rx_msg_busy,
  input wire logic tx_eob_req,
  input wire logic tx_eom_req,
  input wire logic tx_req_done,
  output logic end_of_buffer_interrupt,
  output logic end_of_message_interrupt,
  output logic tx_desc_update_en,
  output logic [NUM_CH-1:0] tx_poll_en,
  output logic [NUM_CH-1:0] rx_chan_en,
  output logic [NUM_CH-1:0] rx_msg_end,
  output logic [tdmec_pkg::MAP_W-1:0] mapped_group_deact,
  output logic desc_valid,
  output tdmec_pkg::tdmec_desc_type desc
);
  import tdmec_pkg::*;
  localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  localparam int DW = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic rst_meta_q, rst_n_q;
  logic [1:0] sync_meta_q, sync_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync_meta_q <= '0;
      sync_q <= '0;
    end else begin
      sync_meta_q <= {rx_sync_pin, tx_sync_pin};
      sync_q <= sync_meta_q;
    end
  end

  // ****************************************
  // Bit-time enable and flywheels
  // ****************************************
  logic [DW-1:0] div_q, div_d;
  logic bit_en_q, bit_en_d, tx_fw_frame_alignment_change, rx_fw_frame_alignment_change;
  always_comb begin
    bit_en_d = (div_q == DW'(BIT_DIV - 1));
    div_d = bit_en_d ? '0 : div_q + DW'(1);
  end
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_q <= '0;
      bit_en_q <= 1'b0;
    end else begin
      div_q <= div_d;
      bit_en_q <= bit_en_d;
    end
  end
  tdmec_flywheel #(.FRAME_BITS(FRAME_BITS)) u_tx_fw (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .bit_en(bit_en_q),
    .sync_in(sync_q[0]),
    .frame_alignment_change(tx_fw_frame_alignment_change)
  );
  tdmec_flywheel #(.FRAME_BITS(FRAME_BITS)) u_rx_fw (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .bit_en(bit_en_q),
    .sync_in(sync_q[1]),
    .frame_alignment_change(rx_fw_frame_alignment_change)
  );

  // ****************************************
  // Registers, bus slave and recovery
  // ****************************************
  logic chan_q, chan_d, tri_q, tri_d, frozen_q, frozen_d, wait_q, wait_d;
  logic [MAP_W-1:0] map_q, map_d, mdeact_q, mdeact_d;
  logic [NUM_CH-1:0] txen_q, txen_d, rxen_q, rxen_d, rxend_q, rxend_d;
  logic [STICKY_W-1:0] sticky_q, sticky_d;
  logic [31:0] rdata_q, rdata_d;
  logic txd_q, txd_d, txoe_q, txoe_d, eob_q, eob_d, eom_q, eom_d;
  logic upd_q, upd_d;
  logic tx_frame_alignment_change, rx_frame_alignment_change, acc, wr;
  always_comb begin
    tx_frame_alignment_change = tx_fw_frame_alignment_change && chan_q;
    rx_frame_alignment_change = rx_fw_frame_alignment_change && chan_q;
    acc = (avs_read || avs_write) && !wait_q;
    wr = acc && avs_write;
    chan_d = chan_q;
    tri_d = tri_q;
    map_d = map_q;
    txen_d = txen_q;
    rxen_d = rxen_q;
    frozen_d = frozen_q;
    sticky_d = sticky_q;
    rdata_d = '0;
    wait_d = !(avs_read || avs_write) || !wait_q;
    if (wr) begin
      case (avs_address)
        REG_CTRL: begin
          chan_d = avs_writedata[CTRL_CHAN_BIT];
          tri_d = avs_writedata[CTRL_TRI_BIT];
          map_d = avs_writedata[CTRL_MAP_LSB +: MAP_W];
        end
        REG_TXEN: begin
          txen_d = avs_writedata[NUM_CH-1:0];
          frozen_d = 1'b0;
        end
        REG_RXEN: rxen_d = avs_writedata[NUM_CH-1:0];
        REG_STAT: sticky_d = sticky_q & ~avs_writedata[STICKY_W-1:0];
        default: ;
      endcase
    end
    if (avs_read && wait_q) begin
      case (avs_address)
        REG_CTRL: begin
          rdata_d[CTRL_CHAN_BIT] = chan_q;
          rdata_d[CTRL_TRI_BIT] = tri_q;
          rdata_d[CTRL_MAP_LSB +: MAP_W] = map_q;
        end
        REG_TXEN: rdata_d[NUM_CH-1:0] = txen_q;
        REG_RXEN: rdata_d[NUM_CH-1:0] = rxen_q;
        REG_STAT: begin
          rdata_d[STICKY_W-1:0] = sticky_q;
          rdata_d[ST_FROZEN] = frozen_q;
        end
        default: ;
      endcase
    end
    // Hardware events set after any clear, so they win
    if (buf_evt.valid) sticky_d[ST_INTERNAL_BUFFER_ERROR] = 1'b1;
    if (own_evt.valid || store_fail_evt.valid) sticky_d[ST_OWNER] = 1'b1;
    if (rx_frame_alignment_change) sticky_d[ST_RX_FRAME_ALIGNMENT_CHANGE] = 1'b1;
    mdeact_d = '0;
    rxend_d = '0;
    if (tx_frame_alignment_change) begin
      sticky_d[ST_TX_FRAME_ALIGNMENT_CHANGE] = 1'b1;
      txen_d = '0;
      frozen_d = 1'b1;
      mdeact_d = map_q;
    end
    rxend_d = rx_frame_alignment_change ? (rx_msg_busy & rxen_q) : '0;
    // Idle level while frozen; all ones or released
    txd_d = frozen_d ? 1'b1 : tx_bit_in;
    txoe_d = frozen_d ? !tri_d : 1'b1;
    eob_d = tx_eob_req && (!frozen_d || tx_req_done);
    eom_d = tx_eom_req && (!frozen_d || tx_req_done);
    upd_d = !frozen_d;
  end
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      chan_q <= 1'b0;
      tri_q <= 1'b0;
      map_q <= '0;
      txen_q <= '0;
      rxen_q <= '0;
      frozen_q <= 1'b0;
      sticky_q <= '0;
      rdata_q <= '0;
      wait_q <= 1'b1;
      mdeact_q <= '0;
      rxend_q <= '0;
      txd_q <= 1'b1;
      txoe_q <= 1'b0;
      eob_q <= 1'b0;
      eom_q <= 1'b0;
      upd_q <= 1'b1;
    end else begin
      chan_q <= chan_d;
      tri_q <= tri_d;
      map_q <= map_d;
      txen_q <= txen_d;
      rxen_q <= rxen_d;
      frozen_q <= frozen_d;
      sticky_q <= sticky_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
      mdeact_q <= mdeact_d;
      rxend_q <= rxend_d;
      txd_q <= txd_d;
      txoe_q <= txoe_d;
      eob_q <= eob_d;
      eom_q <= eom_d;
      upd_q <= upd_d;
    end
  end

  // ****************************************
  // Descriptor generation
  // ****************************************
  tdmec_walk_type walk_q, walk_d;
  logic [CH_W-1:0] wch_q, wch_d;
  logic rpend_q, rpend_d, tpend_q, tpend_d, dval_q, dval_d;
  tdmec_event_type bpend_q, bpend_d, opend_q, opend_d, oevt;
  tdmec_desc_type desc_q, desc_d;
  always_comb begin
    walk_d = walk_q;
    wch_d = wch_q;
    rpend_d = rpend_q || rx_frame_alignment_change;
    tpend_d = tpend_q || tx_frame_alignment_change;
    bpend_d = bpend_q;
    opend_d = opend_q;
    desc_d = '0;
    dval_d = 1'b0;
    oevt = own_evt.valid ? own_evt : store_fail_evt;
    case (walk_q)
      WALK_TX, WALK_RX: begin
        dval_d = 1'b1;
        desc_d.err = ERR_FRAME_ALIGNMENT_CHANGE;
        desc_d.dir = (walk_q == WALK_RX) ? DIR_RX : DIR_TX;
        desc_d.chan = 7'(wch_q);
        wch_d = wch_q + CH_W'(1);
        if (wch_q == CH_W'(NUM_CH - 1)) begin
          wch_d = '0;
          walk_d = WALK_IDLE;
        end
      end
      WALK_IDLE: begin
        if (bpend_q.valid) begin
          dval_d = 1'b1;
          desc_d.err = ERR_INTERNAL_BUFFER_ERROR;
          desc_d.dir = bpend_q.dir;
          desc_d.chan = bpend_q.chan;
          bpend_d.valid = 1'b0;
        end else if (opend_q.valid) begin
          dval_d = 1'b1;
          desc_d.err = ERR_OWNER;
          desc_d.dir = opend_q.dir;
          desc_d.chan = opend_q.chan;
          opend_d.valid = 1'b0;
        end
        // A tx change seen during a walk waits here for its turn
        if (tpend_q || tx_frame_alignment_change) begin
          walk_d = WALK_TX;
          tpend_d = 1'b0;
        end else if (rpend_q || rx_frame_alignment_change) begin
          walk_d = WALK_RX;
          rpend_d = 1'b0;
        end
      end
      default: walk_d = WALK_IDLE;
    endcase
    // A new event refills a slot freed in the same cycle
    if (buf_evt.valid && !bpend_d.valid) bpend_d = buf_evt;
    if (oevt.valid && !opend_d.valid) opend_d = oevt;
  end
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      walk_q <= WALK_IDLE;
      wch_q <= '0;
      rpend_q <= 1'b0;
      tpend_q <= 1'b0;
      bpend_q <= '0;
      opend_q <= '0;
      desc_q <= '0;
      dval_q <= 1'b0;
    end else begin
      walk_q <= walk_d;
      wch_q <= wch_d;
      rpend_q <= rpend_d;
      tpend_q <= tpend_d;
      bpend_q <= bpend_d;
      opend_q <= opend_d;
      desc_q <= desc_d;
      dval_q <= dval_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign tx_serial_data_out = txd_q;
  assign tx_serial_data_oe = txoe_q;
  assign end_of_buffer_interrupt = eob_q;
  assign end_of_message_interrupt = eom_q;
  assign tx_desc_update_en = upd_q;
  assign tx_poll_en = txen_q;
  assign rx_chan_en = rxen_q;
  assign rx_msg_end = rxend_q;
  assign mapped_group_deact = mdeact_q;
  assign desc_valid = dval_q;
  assign desc = desc_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_q);
  property p_err_field;
    !dval_q |-> desc_q.err == ERR_NONE;
  endproperty
  a_err_field: assert property (p_err_field) else $error("code without desc");
  property p_internal_buffer_error;
    buf_evt.valid && !bpend_q.valid && walk_q == WALK_IDLE && !tx_frame_alignment_change
      && !tpend_q && !rpend_q && !rx_frame_alignment_change
      |-> ##2 (dval_q && desc_q.err == ERR_INTERNAL_BUFFER_ERROR);
  endproperty
  a_internal_buffer_error: assert property (p_internal_buffer_error) else $error("buffer error lost");
  property p_frame_alignment_change_walk;
    tx_frame_alignment_change && walk_q == WALK_IDLE |-> ##2 (dval_q && desc_q.err == ERR_FRAME_ALIGNMENT_CHANGE)
      [*2];
  endproperty
  a_frame_alignment_change_walk: assert property (p_frame_alignment_change_walk) else $error("frame_alignment_change walk");
  property p_tx_deact;
    tx_frame_alignment_change |=> txen_q == '0 && mdeact_q == $past(map_q);
  endproperty
  a_tx_deact: assert property (p_tx_deact) else $error("tx not off");
  property p_no_int;
    frozen_q && !wr && !tx_req_done |=> !eob_q && !eom_q;
  endproperty
  a_no_int: assert property (p_no_int) else $error("int after frame_alignment_change");
  property p_no_poll;
    frozen_q |-> tx_poll_en == '0;
  endproperty
  a_no_poll: assert property (p_no_poll) else $error("still polling");
  property p_idle;
    tx_frame_alignment_change |=> txd_q && (txoe_q == !tri_q);
  endproperty
  a_idle: assert property (p_idle) else $error("tx not idle");
  property p_rx_end;
    rx_frame_alignment_change |=> rxend_q == $past(rx_msg_busy & rxen_q);
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("rx not ended");
  property p_rx_keep;
    rx_frame_alignment_change && !wr |=> $stable(rxen_q);
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("rx disabled");
  property p_owner;
    dval_q && desc_q.err == ERR_OWNER |-> $past(opend_q.valid);
  endproperty
  a_owner: assert property (p_owner) else $error("owner cause");
  c_tx_frame_alignment_change: cover property (tx_frame_alignment_change ##1 frozen_q);
  c_rx_frame_alignment_change: cover property (rx_frame_alignment_change && rx_msg_busy != '0);
  c_owner: cover property (dval_q && desc_q.err == ERR_OWNER);
endmodule
`default_nettype wire

// ### tb/tdmec_frame_src.sv
/*
 Frame sync source standing in for the framer on the serial line.
 Assumes clk_sys; sync stays low while the source is disabled.
*/
`timescale 1ns/1ns
`default_nettype none
module tdmec_frame_src #(
  parameter int FRAME_BITS = 16,
  parameter int BIT_DIV = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic en,
  input wire logic slip,
  output logic sync_out
);
  localparam int FCLK = FRAME_BITS * BIT_DIV;
  int cnt_q;
  // ****************************************
  // Frame counter; a slip jumps half a frame
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 0;
    end else if (slip) begin
      cnt_q <= (cnt_q + FCLK / 2) % FCLK;
    end else begin
      cnt_q <= (cnt_q + 1) % FCLK;
    end
  end
  // Sync covers one whole bit time
  assign sync_out = en && (cnt_q < BIT_DIV);
endmodule
`default_nettype wire

// ### tb/tb_tdmec_top.sv
/*
 Self-checking bench of the TDM error classifier.
 Assumes the design package and tdmec_frame_src are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_tdmec_top;
  import tdmec_pkg::*;
  localparam int NCH = 8;
  logic clk_sys = 1'b0, rstn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic tx_sync_pin, rx_sync_pin, tx_bit_in = 1'b0;
  logic tx_serial_data_out, tx_serial_data_oe, desc_valid;
  tdmec_event_type buf_evt = '0, own_evt = '0, store_fail_evt = '0;
  logic [NCH-1:0] rx_msg_busy = '0, tx_poll_en, rx_chan_en, rx_msg_end;
  logic [NCH-1:0] end_seen = '0;
  logic tx_eob_req = 1'b0, tx_eom_req = 1'b0, tx_req_done = 1'b0;
  logic end_of_buffer_interrupt, end_of_message_interrupt;
  logic tx_desc_update_en;
  logic [MAP_W-1:0] mapped_group_deact, map_seen = '0;
  tdmec_desc_type desc;
  logic [1:0] sync_en = 2'h0, slip = 2'h0;
  logic [7:0] rnd = 8'h2E;
  int err_count = 0, total_checks = 0, cycles = 0, dv_cnt = 0;

  tdmec_top #(.NUM_CH(NCH), .BIT_DIV(2), .FRAME_BITS(16)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_sync_pin(tx_sync_pin),
    .rx_sync_pin(rx_sync_pin), .tx_bit_in(tx_bit_in),
    .tx_serial_data_out(tx_serial_data_out),
    .tx_serial_data_oe(tx_serial_data_oe), .buf_evt(buf_evt),
    .own_evt(own_evt), .store_fail_evt(store_fail_evt),
    .rx_msg_busy(rx_msg_busy), .tx_eob_req(tx_eob_req),
    .tx_eom_req(tx_eom_req), .tx_req_done(tx_req_done),
    .end_of_buffer_interrupt(end_of_buffer_interrupt),
    .end_of_message_interrupt(end_of_message_interrupt),
    .tx_desc_update_en(tx_desc_update_en), .tx_poll_en(tx_poll_en),
    .rx_chan_en(rx_chan_en), .rx_msg_end(rx_msg_end),
    .mapped_group_deact(mapped_group_deact), .desc_valid(desc_valid),
    .desc(desc));
  tdmec_frame_src #(.FRAME_BITS(16), .BIT_DIV(2)) i_tx_src (
    .clk_sys(clk_sys), .rst_n(rstn), .en(sync_en[0]), .slip(slip[0]),
    .sync_out(tx_sync_pin));
  tdmec_frame_src #(.FRAME_BITS(16), .BIT_DIV(2)) i_rx_src (
    .clk_sys(clk_sys), .rst_n(rstn), .en(sync_en[1]), .slip(slip[1]),
    .sync_out(rx_sync_pin));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic tdmec_desc_type mk(input logic [3:0] e,
                                        input logic d, input logic [6:0] c);
    tdmec_desc_type r;
    r = '0;
    r.err = e;
    r.dir = d;
    r.chan = c;
    return r;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [3:0] a,
                       input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic walk(input logic [3:0] e, input logic d, input int n,
                      input int first);
    int k;
    k = 0;
    while (desc_valid !== 1'b1 && k < 200) begin
      @(posedge clk_sys);
      k++;
    end
    for (int i = 0; i < n; i++) begin
      chk("desc", desc, mk(e, d, 7'(first + i)));
      @(posedge clk_sys);
    end
  endtask
  task automatic evt(input int kind, input logic d, input logic [6:0] c);
    tdmec_event_type ev;
    ev = '{valid: 1'b1, dir: d, chan: c};
    @(posedge clk_sys);
    case (kind)
      0: buf_evt <= ev;
      1: own_evt <= ev;
      default: store_fail_evt <= ev;
    endcase
    @(posedge clk_sys);
    buf_evt <= '0;
    own_evt <= '0;
    store_fail_evt <= '0;
    walk(kind == 0 ? ERR_INTERNAL_BUFFER_ERROR : ERR_OWNER, d, 1, c);
  endtask
  task automatic irq(input logic done, input logic exp);
    logic [1:0] req;
    rnd = nxt(rnd);
    req = (rnd[1:0] == 2'h0) ? 2'h3 : rnd[1:0];
    @(posedge clk_sys);
    tx_eob_req <= req[0];
    tx_eom_req <= req[1];
    tx_req_done <= done;
    @(posedge clk_sys);
    tx_eob_req <= 1'b0;
    tx_eom_req <= 1'b0;
    tx_req_done <= 1'b0;
    @(posedge clk_sys);
    chk("eob", end_of_buffer_interrupt, exp & req[0]);
    chk("eom", end_of_message_interrupt, exp & req[1]);
  endtask
  task automatic txd(input logic idle, input logic exp_oe);
    repeat (6) begin
      @(posedge clk_sys);
      rnd = nxt(rnd);
      tx_bit_in <= rnd[0];
      @(posedge clk_sys);
      @(posedge clk_sys);
      chk("tx_serial_data_out", tx_serial_data_out, idle ? 1'b1 : rnd[0]);
      chk("oe", tx_serial_data_oe, exp_oe);
    end
  endtask
  task automatic slip_pulse(input logic [1:0] m);
    @(posedge clk_sys);
    slip <= m;
    @(posedge clk_sys);
    slip <= 2'h0;
  endtask

  // ****************************************
  // Clock, monitor, timeout
  // ****************************************
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    map_seen <= map_seen | mapped_group_deact;
    end_seen <= end_seen | rx_msg_end;
    dv_cnt += (desc_valid === 1'b1);
    if (cycles == 5000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    int dv0;
    repeat (8) @(posedge clk_sys);
    chk("rst_wait", avs_waitrequest, 1'b1);
    chk("rst_tx_serial_data_out", {tx_serial_data_out, tx_serial_data_oe}, 2'h2);
    chk("rst_upd", {tx_desc_update_en, desc_valid}, 2'h2);
    rstn <= 1'b1;
    sync_en <= 2'h3;
    repeat (3) @(posedge clk_sys);
    rdchk("stat0", REG_STAT, 32'h0);
    bus(1'b1, 4'h2, 32'hFFFFFFFF);
    rdchk("unmapped", 4'h2, 32'h0);
    rdchk("ctrl0", REG_CTRL, 32'h0);
    bus(1'b1, REG_CTRL, 32'h51);
    bus(1'b1, REG_TXEN, 32'hFF);
    bus(1'b1, REG_RXEN, 32'hFF);
    rdchk("ctrl", REG_CTRL, 32'h51);
    chk("poll", tx_poll_en, 8'hFF);
    repeat (100) @(posedge clk_sys);
    txd(1'b0, 1'b1);
    irq(1'b0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      rnd = nxt(rnd);
      evt(i % 3, rnd[7], 7'(rnd[2:0]));
    end
    evt(0, DIR_RX, 7'(NCH - 1));
    rdchk("stat_ev", REG_STAT, 32'h9);
    bus(1'b1, REG_STAT, 32'hF);
    rdchk("stat_clr", REG_STAT, 32'h0);
    dv0 = dv_cnt;
    slip_pulse(2'h1);
    walk(ERR_FRAME_ALIGNMENT_CHANGE, DIR_TX, NCH, 0);
    chk("tx_walk", dv_cnt - dv0, NCH);
    sync_en[0] <= 1'b0;
    chk("map", map_seen, 4'h5);
    chk("poll_off", tx_poll_en, 8'h00);
    chk("upd_off", tx_desc_update_en, 1'b0);
    rdchk("stat_tc", REG_STAT, 32'h12);
    rdchk("txen_tc", REG_TXEN, 32'h0);
    txd(1'b1, 1'b1);
    irq(1'b0, 1'b0);
    irq(1'b1, 1'b1);
    bus(1'b1, REG_CTRL, 32'h53);
    txd(1'b1, 1'b0);
    bus(1'b1, REG_TXEN, 32'hFF);
    // The write lands on the edge the bus task returns on
    @(posedge clk_sys);
    chk("upd_on", tx_desc_update_en, 1'b1);
    txd(1'b0, 1'b1);
    bus(1'b1, REG_STAT, 32'hF);
    rnd = nxt(rnd);
    rx_msg_busy <= rnd | 8'h81;
    slip_pulse(2'h2);
    walk(ERR_FRAME_ALIGNMENT_CHANGE, DIR_RX, NCH, 0);
    sync_en[1] <= 1'b0;
    chk("rx_end", end_seen, rx_msg_busy);
    chk("rx_en", rx_chan_en, 8'hFF);
    rdchk("stat_rc", REG_STAT, 32'h4);
    rx_msg_busy <= '0;
    bus(1'b1, REG_STAT, 32'hF);
    bus(1'b1, REG_CTRL, 32'h50);
    dv0 = dv_cnt;
    sync_en <= 2'h3;
    slip_pulse(2'h3);
    repeat (150) @(posedge clk_sys);
    chk("no_frame_alignment_change", dv_cnt - dv0, 32'h0);
    rdchk("stat_nc", REG_STAT, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
